// ===== adc_serial_readout_modes_bench.sv
// Bench: both link ends joined, three readout modes, user buffer stall
`timescale 1ns/1ps
module adc_serial_readout_modes_bench
   import asrm_pkg::*;
;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [RES_W-1:0] sample_in = 16'h0000;
   logic four_wire_sel = 1'b0;
   logic busy_ind_sel = 1'b0;
   logic run_en = 1'b0;
   asrm_mode_e mode_sel = MODE_3W;
   logic rd_ready = 1'b0;
   logic [RES_W-1:0] rd_data;
   logic rd_valid;
   logic powered_down;
   logic conv_busy;
   asrm_mode_e mode_out;
   logic [RES_W-1:0] mon_word = 16'h0000;
   int num_errors = 0;
   int checks_done = 0;
   // Daisy before 4-wire: a low idle input would select a 4-wire device again
   asrm_mode_e modes [3] = '{MODE_3W, MODE_DAISY, MODE_4W};
   logic fws [3] = '{1'b0, 1'b0, 1'b1};
   logic [RES_W-1:0] samps [3] = '{16'ha5c3, 16'h8001, 16'h7ffe};
   int nw;
   int busy_seen;

   asrm_if link ();
   asrm_dev i_asrm_dev (.clk_sys(clk_sys), .arst_n(arst_n), .link(link),
      .sample_in(sample_in), .four_wire_sel(four_wire_sel), .busy_ind_sel(busy_ind_sel),
      .powered_down(powered_down), .conv_busy(conv_busy), .mode_out(mode_out));
   asrm_host i_asrm_host (.clk_sys(clk_sys), .arst_n(arst_n), .link(link), .run_en(run_en),
      .mode_sel(mode_sel), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready));
   asrm_chk i_asrm_chk (.clk_sys(clk_sys), .arst_n(arst_n), .convert_start(link.convert_start),
      .din(link.din), .sclk(link.sclk), .dout(link.dout), .dout_oe(link.dout_oe));

   always #5 clk_sys = ~clk_sys;

   // Wire view: bits taken while the serial clock is high
   always @(posedge link.sclk)
   begin
      if (link.dout_oe === 1'b1)
         mon_word <= {mon_word[RES_W-2:0], link.dout};
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wait_busy();
      int n;
      n = 0;
      while (conv_busy !== 1'b1 && n < 400)
      begin
         @(negedge clk_sys);
         n++;
      end
      check(32'(n < 400), 32'h1);
      check(32'(powered_down), 32'h0);
   endtask : wait_busy

   task automatic get_word(input logic [RES_W-1:0] exp_w, input asrm_mode_e exp_m);
      int n;
      n = 0;
      // Let a pop from a previous call settle first
      @(negedge clk_sys);
      while (rd_valid !== 1'b1 && n < 600)
      begin
         @(negedge clk_sys);
         n++;
      end
      check(32'(n < 600), 32'h1);
      check(32'(rd_data), 32'(exp_w));
      check(32'(mon_word), 32'(exp_w));
      check(32'(mode_out), 32'(exp_m));
      check(32'(powered_down), 32'h1);
      @(posedge clk_sys);
      rd_ready <= 1'b1;
      @(posedge clk_sys);
      rd_ready <= 1'b0;
   endtask : get_word

   task automatic drain(input logic [RES_W-1:0] exp_w, input asrm_mode_e exp_m, output int cnt);
      repeat (400) @(negedge clk_sys);
      cnt = 0;
      while (rd_valid === 1'b1 && cnt < 8)
      begin
         get_word(exp_w, exp_m);
         cnt++;
         @(negedge clk_sys);
      end
   endtask : drain

   task automatic report_and_stop();
      $display("Errors %0d, checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      report_and_stop();
   end

   initial
   begin
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      // Each readout mode, two back-to-back conversions
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk_sys);
         mode_sel <= modes[i];
         four_wire_sel <= fws[i];
         sample_in <= samps[i];
         run_en <= 1'b1;
         wait_busy();
         get_word(samps[i], modes[i]);
         get_word(samps[i], modes[i]);
         @(posedge clk_sys);
         run_en <= 1'b0;
         drain(samps[i], modes[i], nw);
      end
      // Receiver stalls: two words held, host waits, nothing lost
      @(posedge clk_sys);
      mode_sel <= MODE_3W;
      four_wire_sel <= 1'b0;
      sample_in <= 16'h1234;
      run_en <= 1'b1;
      repeat (800) @(negedge clk_sys);
      check(32'(rd_valid), 32'h1);
      busy_seen = 0;
      repeat (300)
      begin
         @(negedge clk_sys);
         if (conv_busy !== 1'b0)
            busy_seen++;
      end
      check(32'(busy_seen), 32'h0);
      @(posedge clk_sys);
      run_en <= 1'b0;
      drain(16'h1234, MODE_3W, nw);
      check(32'(nw), 32'h3);
      // Busy variant: flag bit first, result follows one bit later
      @(posedge clk_sys);
      busy_ind_sel <= 1'b1;
      run_en <= 1'b1;
      wait_busy();
      get_word(16'h891a, MODE_3W);
      @(posedge clk_sys);
      run_en <= 1'b0;
      drain(16'h891a, MODE_3W, nw);
      report_and_stop();
   end
endmodule : adc_serial_readout_modes_bench

// ===== asrm_chk.sv
// Link checker: timing relations on the converter readout pins
`timescale 1ns/1ps
module asrm_chk
   import asrm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic convert_start,
   input wire logic din,
   input wire logic sclk,
   input wire logic dout,
   input wire logic dout_oe
);
   logic [6:0] since_start_r;
   logic [4:0] falls_r;
   logic sclk_d_r;
   logic cs_d_r;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   // Cycles since the last start edge, saturating
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         since_start_r <= 7'h7f;
         cs_d_r <= 1'b0;
      end
      else
      begin
         cs_d_r <= convert_start;
         if (convert_start && !cs_d_r)
            since_start_r <= 7'h00;
         else if (since_start_r != 7'h7f)
            since_start_r <= since_start_r + 7'h01;
      end
   end

   // Falling serial edges since the last start edge
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         falls_r <= BIT_LAST;
         sclk_d_r <= 1'b0;
      end
      else
      begin
         sclk_d_r <= sclk;
         if (convert_start && !cs_d_r)
            falls_r <= 5'h00;
         else if (sclk_d_r && !sclk && falls_r != 5'h1f)
            falls_r <= falls_r + 5'h01;
      end
   end

   property p_start_spacing;
      $rose(convert_start) |-> since_start_r >= CYCLE_CYC - 7'h01;
   endproperty
   a_start_spacing: assert property (p_start_spacing)
      else $error("conversion starts too close together");
   property p_wait_conv;
      sclk |-> since_start_r >= WAIT_CYC;
   endproperty
   a_wait_conv: assert property (p_wait_conv)
      else $error("serial clock before conversion can be done");
   property p_sclk_high;
      $rose(sclk) |-> sclk [*4] ##1 !sclk;
   endproperty
   a_sclk_high: assert property (p_sclk_high)
      else $error("serial clock high phase not four cycles");
   property p_sclk_low;
      $fell(sclk) |-> !sclk [*4];
   endproperty
   a_sclk_low: assert property (p_sclk_low)
      else $error("serial clock low phase too short");
   property p_start_quiet;
      $rose(convert_start) |-> !sclk && !$past(sclk) ##1 !sclk;
   endproperty
   a_start_quiet: assert property (p_start_quiet)
      else $error("serial clock moves around start edge");
   property p_start_din;
      $rose(convert_start) |-> $stable(din) ##1 $stable(din);
   endproperty
   a_start_din: assert property (p_start_din)
      else $error("serial input not steady around start edge");
   property p_start_rel;
      $rose(convert_start) |-> !dout_oe;
   endproperty
   a_start_rel: assert property (p_start_rel)
      else $error("data output driven at start edge");
   property p_sclk_sel;
      sclk |-> !convert_start || !din;
   endproperty
   a_sclk_sel: assert property (p_sclk_sel)
      else $error("serial clock while not selected");
   property p_oe_sel;
      dout_oe |-> !convert_start || !din;
   endproperty
   a_oe_sel: assert property (p_oe_sel)
      else $error("data output driven while not selected");
   property p_bits_max;
      (sclk_d_r && !sclk) |-> falls_r < BIT_LAST;
   endproperty
   a_bits_max: assert property (p_bits_max)
      else $error("more than sixteen serial clocks in a frame");
   property p_frame_len;
      $rose(convert_start) |-> falls_r == BIT_LAST;
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("frame did not have sixteen serial clocks");
   property p_dout_hold;
      (sclk && sclk_d_r && dout_oe) |-> $stable(dout);
   endproperty
   a_dout_hold: assert property (p_dout_hold)
      else $error("data output moved while serial clock high");
endmodule : asrm_chk

// ===== asrm_dev.sv
// Converter end: conversion timing, mode capture and serial result readout
//
// Summary of operation
// RULE1 - 3-wire: convert_start low drives out MSB
// RULE2 - 3-wire: release output on high or last edge
// RULE3 - Next result bit on each falling serial edge
// RULE4 - 4-wire: serial input acts as select
// RULE5 - 4-wire: select low drives out MSB
// RULE6 - 4-wire: release on select high or last edge
// RULE7 - Host holds input high to pick 4-wire
// RULE8 - Host holds input low to pick daisy
// RULE9 - Daisy: serial clock steady around start edge
// RULE10 - Daisy: upstream bits shift behind own result
// RULE11 - Busy variants keep the same timing
// RULE12 - Input level at start picks the mode
// RULE13 - 3-wire: convert_start doubles as select
// RULE14 - Power down from conversion end through acquisition
// RULE15 - Conversion ends within bounded time; host spaces starts
// RULE16 - Sixteen bits, MSB first, one per clock
`timescale 1ns/1ps
module asrm_dev
   import asrm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   asrm_if.dev link,
   input wire logic [RES_W-1:0] sample_in,
   input wire logic four_wire_sel,
   input wire logic busy_ind_sel,
   output logic powered_down,
   output logic conv_busy,
   output asrm_mode_e mode_out
);

   // Pin synchronisers into the conversion clock
   logic cnv_s1_r;
   logic cnv_s2_r;
   logic cnv_s3_r;
   logic din_s1_r;
   logic din_s2_r;
   logic start_pulse;

   // Conversion side state
   asrm_dst_e state_r;
   logic [6:0] cnt_r;
   asrm_mode_e mode_r;
   logic busy_r;
   logic [RES_W-1:0] held_r;
   logic [RES_W-1:0] result_r;
   logic ready_r;

   // Link side state, on the serial clock
   logic [4:0] pos_r;
   logic [RES_W-1:0] chain_r;
   logic frame_sel;
   logic link_rst_n;
   logic [4:0] pos_last;
   logic [4:0] data_pos;
   logic cs_mode;
   logic busy_low;
   logic shifting;
   logic bit_val;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnv_s1_r <= 1'b0;
         cnv_s2_r <= 1'b0;
         cnv_s3_r <= 1'b0;
         din_s1_r <= 1'b0;
         din_s2_r <= 1'b0;
      end
      else
      begin
         cnv_s1_r <= link.convert_start;
         cnv_s2_r <= cnv_s1_r;
         cnv_s3_r <= cnv_s2_r;
         din_s1_r <= link.din;
         din_s2_r <= din_s1_r;
      end
   end

   // Rising edge of convert_start, seen after synchronisation
   assign start_pulse = cnv_s2_r & ~cnv_s3_r;

   // Acquire / convert sequencing; edges during a conversion are ignored
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= DS_ACQ;
         cnt_r <= 7'h00;
      end
      else
      begin
         case (state_r)
            DS_ACQ:
            begin
               cnt_r <= 7'h00;
               if (start_pulse)
               begin
                  state_r <= DS_CONV;
               end
            end
            DS_CONV:
            begin
               cnt_r <= cnt_r + 7'h01;
               if (cnt_r == CONV_CYC - 7'h01) // see RULE15
               begin
                  state_r <= DS_ACQ;
               end
            end
            default:
            begin
               state_r <= DS_ACQ;
               cnt_r <= 7'h00;
            end
         endcase
      end
   end

   // Mode and busy variant caught at each conversion start
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode_r <= MODE_3W;
         busy_r <= 1'b0;
      end
      else if (state_r == DS_ACQ && start_pulse)
      begin
         if (!din_s2_r) // see RULE8
         begin
            mode_r <= MODE_DAISY; // see RULE12
         end
         else if (four_wire_sel) // see RULE7
         begin
            mode_r <= MODE_4W; // see RULE12
         end
         else
         begin
            mode_r <= MODE_3W; // see RULE12
         end
         busy_r <= busy_ind_sel; // see RULE11
      end
   end

   // Sample taken at the start, result published at the end
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         held_r <= 16'h0000;
         result_r <= 16'h0000;
         ready_r <= 1'b0;
      end
      else if (state_r == DS_ACQ && start_pulse)
      begin
         held_r <= sample_in;
         ready_r <= 1'b0;
      end
      else if (state_r == DS_CONV && cnt_r == CONV_CYC - 7'h01)
      begin
         result_r <= held_r;
         ready_r <= 1'b1;
      end
   end

   // Powered down whenever not converting
   assign powered_down = (state_r == DS_ACQ); // see RULE14
   assign conv_busy = (state_r == DS_CONV);
   assign mode_out = mode_r;

   // Select pin per mode; mode_r and result_r stay still while a frame is open
   assign cs_mode = (mode_r != MODE_DAISY);
   assign frame_sel = (mode_r == MODE_4W) ? ~link.din // see RULE4
                                          : ~link.convert_start; // see RULE13
   // Closing the select clears the link side without needing a clock edge
   assign link_rst_n = arst_n & frame_sel & ready_r;
   assign pos_last = busy_r ? BIT_LAST_BUSY : BIT_LAST;

   // Bit position advances on falling serial edges, stops after the last
   always_ff @(negedge link.sclk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         pos_r <= 5'h00;
      end
      else if (pos_r != pos_last)
      begin
         pos_r <= pos_r + 5'h01; // see RULE3
      end
   end

   // Upstream word captured on falling edges, passed on behind our own
   always_ff @(negedge link.sclk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         chain_r <= 16'h0000;
      end
      else
      begin
         chain_r <= {chain_r[RES_W-2:0], link.din}; // see RULE10
      end
   end

   // With a busy indicator one flag bit leads the result
   assign data_pos = pos_r - {4'h0, busy_r};

   always_comb
   begin
      if (busy_r && pos_r == 5'h00)
      begin
         bit_val = 1'b1; // see RULE11
      end
      else if (data_pos < BIT_LAST)
      begin
         bit_val = result_r[~data_pos[3:0]]; // see RULE16
      end
      else
      begin
         bit_val = chain_r[RES_W-1]; // see RULE10
      end
   end

   // Busy variant holds the line low while a selected conversion runs, except in daisy
   assign busy_low = frame_sel & busy_r & cs_mode & ~ready_r;
   // Driving stops when select closes or, outside daisy, after the last falling edge
   assign shifting = frame_sel & ready_r & (~cs_mode | (pos_r != pos_last)); // see RULE2 RULE6

   // MSB, or the flag bit with a busy indicator, appears as soon as select falls, with no serial edge needed
   assign link.dout_oe = busy_low | shifting; // see RULE1
   assign link.dout = shifting & bit_val; // see RULE5
   // In 4-wire the same path releases on select high or last edge; see RULE6

   // Daisy start edge relies on a steady serial clock; see RULE9

endmodule : asrm_dev

// ===== asrm_host.sv
// Host end: starts conversions, clocks out results, buffers words for the user
`timescale 1ns/1ps
module asrm_host
   import asrm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   asrm_if.host link,
   input wire logic run_en,
   input wire asrm_mode_e mode_sel,
   output logic [RES_W-1:0] rd_data,
   output logic rd_valid,
   input wire logic rd_ready
);

   asrm_hst_e state_r;
   logic [6:0] wait_r;
   logic [6:0] cyc_r;
   logic cnv_r;
   logic din_r;
   logic sclk_r;
   logic [2:0] div_r;
   logic [4:0] bit_r;
   logic [RES_W-1:0] shift_r;
   logic do_s1_r;
   logic do_s2_r;
   logic [RES_W-1:0] mem_r [2];
   logic wp_r;
   logic rp_r;
   logic [1:0] cnt_r;
   logic push;
   logic pop;
   logic buf_ready;
   logic cs_idle;

   assign link.convert_start = cnv_r;
   assign link.din = din_r;
   assign link.sclk = sclk_r;

   // Idle select level: high except in daisy, where the input is tied low
   assign cs_idle = (mode_sel != MODE_DAISY); // see RULE8

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         do_s1_r <= 1'b0;
         do_s2_r <= 1'b0;
      end
      else
      begin
         do_s1_r <= link.dout;
         do_s2_r <= do_s1_r;
      end
   end

   // Time since the last start, saturating at the cycle time
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cyc_r <= CYCLE_CYC;
      end
      else if (state_r == HS_START)
      begin
         cyc_r <= 7'h01; // see RULE15
      end
      else if (cyc_r != CYCLE_CYC)
      begin
         cyc_r <= cyc_r + 7'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= HS_IDLE;
         wait_r <= 7'h00;
         cnv_r <= 1'b0;
         din_r <= 1'b1;
         sclk_r <= 1'b0;
         div_r <= 3'h0;
         bit_r <= 5'h00;
         shift_r <= 16'h0000;
      end
      else
      begin
         case (state_r)
            HS_IDLE:
            begin
               cnv_r <= 1'b0;
               din_r <= cs_idle;
               wait_r <= 7'h00;
               if (run_en)
               begin
                  state_r <= HS_SETUP;
               end
            end
            HS_SETUP:
            begin
               // Mode level set up and convert_start low long enough
               wait_r <= wait_r + 7'h01;
               if (wait_r >= CNV_WL_CYC && wait_r >= DI_SU_CYC && cyc_r == CYCLE_CYC)
               begin
                  state_r <= HS_START;
               end
            end
            HS_START:
            begin
               cnv_r <= 1'b1; // see RULE7 RULE8 RULE9
               wait_r <= 7'h00;
               state_r <= HS_CONV;
            end
            HS_CONV:
            begin
               wait_r <= wait_r + 7'h01;
               if (wait_r == WAIT_CYC + QUIET_CYC + CNV_WH_CYC)
               begin
                  if (mode_sel == MODE_4W)
                  begin
                     din_r <= 1'b0; // see RULE4
                  end
                  else
                  begin
                     cnv_r <= 1'b0;
                  end
                  div_r <= 3'h0;
                  bit_r <= 5'h00;
                  state_r <= HS_FRAME;
               end
            end
            HS_FRAME:
            begin
               div_r <= div_r + 3'h1;
               if (div_r == SCLK_HALF - 3'h1)
               begin
                  sclk_r <= 1'b1;
               end
               else if (div_r == SCLK_HALF + SCLK_HALF - 3'h1)
               begin
                  sclk_r <= 1'b0;
                  shift_r <= {shift_r[RES_W-2:0], do_s2_r};
                  bit_r <= bit_r + 5'h01;
                  if (bit_r == BIT_LAST - 5'h01)
                  begin
                     state_r <= HS_END;
                  end
               end
            end
            HS_END:
            begin
               din_r <= cs_idle;
               if (buf_ready)
               begin
                  state_r <= HS_IDLE;
               end
            end
            default:
            begin
               state_r <= HS_IDLE;
            end
         endcase
      end
   end

   // Two-entry buffer; a full buffer holds the host in HS_END
   assign buf_ready = (cnt_r != 2'h2);
   assign push = (state_r == HS_END) & buf_ready;
   assign pop = rd_valid & rd_ready;
   assign rd_valid = (cnt_r != 2'h0);
   assign rd_data = mem_r[rp_r];

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mem_r[0] <= 16'h0000;
         mem_r[1] <= 16'h0000;
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            mem_r[wp_r] <= shift_r;
            wp_r <= ~wp_r;
         end
         if (pop)
         begin
            rp_r <= ~rp_r;
         end
         if (push && !pop)
         begin
            cnt_r <= cnt_r + 2'h1;
         end
         else if (pop && !push)
         begin
            cnt_r <= cnt_r - 2'h1;
         end
      end
   end

endmodule : asrm_host

// ===== asrm_if.sv
// Link pins between the converter end and the host end
`timescale 1ns/1ps
interface asrm_if;
   logic convert_start;
   logic din;
   logic sclk;
   logic dout;
   logic dout_oe;

   modport dev (
      input convert_start,
      input din,
      input sclk,
      output dout,
      output dout_oe
   );

   modport host (
      output convert_start,
      output din,
      output sclk,
      input dout,
      input dout_oe
   );
endinterface : asrm_if

// ===== asrm_pkg.sv
// Shared constants, timing counts and types of the converter readout link
package asrm_pkg;

   localparam int RES_W = 16;
   localparam int CLK_MHZ = 100;

   // Link timing figures in their own units
   localparam int T_CONV_MIN_NS = 500;
   localparam int T_CONV_MAX_NS = 710;
   localparam int T_CYCLE_NS = 1000;
   localparam int T_CNV_WH_NS = 10;
   localparam int T_CNV_WL_NS = 20;
   localparam int T_QUIET_NS = 20;
   localparam int T_DI_SU_PS = 7500;

   // Least time in ps to whole clk_sys cycles, never below one
   function automatic int cyc_up(input int t_ps);
      int c;
      c = (t_ps * CLK_MHZ + 999999) / 1000000;
      return (c < 1) ? 1 : c;
   endfunction : cyc_up

   localparam logic [6:0] CONV_CYC = 7'(cyc_up(T_CONV_MIN_NS * 1000));
   localparam logic [6:0] WAIT_CYC = 7'(cyc_up(T_CONV_MAX_NS * 1000));
   localparam logic [6:0] CYCLE_CYC = 7'(cyc_up(T_CYCLE_NS * 1000));
   localparam logic [6:0] CNV_WH_CYC = 7'(cyc_up(T_CNV_WH_NS * 1000));
   localparam logic [6:0] CNV_WL_CYC = 7'(cyc_up(T_CNV_WL_NS * 1000));
   localparam logic [6:0] QUIET_CYC = 7'(cyc_up(T_QUIET_NS * 1000));
   localparam logic [6:0] DI_SU_CYC = 7'(cyc_up(T_DI_SU_PS));

   // Serial clock made by the host: half period in clk_sys cycles
   localparam logic [2:0] SCLK_HALF = 3'h4;
   localparam logic [4:0] BIT_LAST = 5'h10;
   localparam logic [4:0] BIT_LAST_BUSY = 5'h11;

   typedef enum logic [2:0] {
      MODE_3W = 3'h1,
      MODE_4W = 3'h2,
      MODE_DAISY = 3'h4
   } asrm_mode_e;

   typedef enum logic [1:0] {
      DS_ACQ = 2'h1,
      DS_CONV = 2'h2
   } asrm_dst_e;

   typedef enum logic [5:0] {
      HS_IDLE = 6'h01,
      HS_SETUP = 6'h02,
      HS_START = 6'h04,
      HS_CONV = 6'h08,
      HS_FRAME = 6'h10,
      HS_END = 6'h20
   } asrm_hst_e;

endpackage : asrm_pkg
